// file: common/pcc_pkg.sv
// Purpose: Constants, field layout and helpers for the clock configuration block
// Assumes: 200 MHz mclk_in, 8-bit register address, 32-bit register data
// Notes: Register offsets and the loop check timeout are local choices
// Operation
// R1: Bits 16:14 reserved, read as zero
// R2: Bit 13 drives loop power-down, resets one
// R3: Bit 12 set keeps loop clock inside
// R4: Loop runs only when bits 13, 12 clear
// R5: Bypass bit 11 set selects oscillator clock
// R6: Bypass clear selects divided loop clock
// R7: Software keeps converter clock 14 to 18 MHz
// R8: Bit 10 enables loop check timer, interrupt
// R9: Bits 19:17 predivide system clock by powers
// R10: Bit 20 selects predivided clock for PWM
// R11: Loop source always uses the system divider
package pcc_pkg;

	localparam logic [7:0]  ADDR_INT_STATUS  = 8'h50;
	localparam logic [7:0]  ADDR_INT_ENABLE  = 8'h54;
	localparam logic [7:0]  ADDR_INT_CLEAR   = 8'h58;
	localparam logic [7:0]  ADDR_CLK_CFG     = 8'h60;

	localparam int          BIT_PWM_SEL      = 20;
	localparam int          PWM_CLOCK_PREDIVIDER_LSB       = 17;
	localparam int          PWM_CLOCK_PREDIVIDER_MSB       = 19;
	localparam int          RSVD_LSB         = 14;
	localparam int          RSVD_MSB         = 16;
	localparam int          BIT_LOOP_POWER_OFF        = 13;
	localparam int          BIT_OEN          = 12;
	localparam int          BIT_BYPASS       = 11;
	localparam int          BIT_CHECK        = 10;
	localparam int          INT_LOOP_FAIL    = 0;

	localparam logic        RST_PWM_SEL      = 1'b0;
	localparam logic [2:0]  RST_PWM_CLOCK_PREDIVIDER       = 3'h7;
	localparam logic        RST_LOOP_POWER_OFF        = 1'b1;
	localparam logic        RST_OEN          = 1'b1;
	localparam logic        RST_BYPASS       = 1'b1;
	localparam logic        RST_CHECK        = 1'b0;

	localparam int          CLK_PERIOD_PS    = 5000;
	localparam int          LOOP_TIMEOUT_NS  = 1000;
	localparam int          LOOP_TIMEOUT_CYC = (LOOP_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

	// Low-bit mask of the power-of-two predivider
	function automatic logic [5:0] pcc_pwm_mask(input logic [2:0] code);
		case (code)
			3'h0:    return 6'h01;
			3'h1:    return 6'h03;
			3'h2:    return 6'h07;
			3'h3:    return 6'h0f;
			3'h4:    return 6'h1f;
			default: return 6'h3f;
		endcase
	endfunction : pcc_pwm_mask

endpackage : pcc_pkg

// file: hdl/pcc_pwm_div.sv
// Purpose: Power-of-two predivider of the system clock enable for the PWM unit
// Assumes: sys_tick_in is a one-cycle enable on mclk_in
// Notes: Output ticks come one mclk_in cycle after their system ticks
`timescale 1ns/1ps
`default_nettype none
module pcc_pwm_div #(
	parameter int CNT_W = 6
) (
	input  wire logic        mclk_in,
	input  wire logic        arst_n_in,
	input  wire logic        sys_tick_in,
	input  wire logic [2:0]  code_in,
	output var  logic        tick_out
);
	import pcc_pkg::*;

	if (CNT_W < 6) begin : g_chk
		$error("CNT_W must be at least 6");
	end

	logic [CNT_W-1:0] cnt_ff;
	logic             hit;

	// R9: divide by power
	assign hit = sys_tick_in && ((cnt_ff[5:0] & pcc_pwm_mask(code_in)) == pcc_pwm_mask(code_in));

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_ff <= '0;
		end else if (sys_tick_in) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= hit;
		end
	end

	AST_PWM_SPACING: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R9
		(sys_tick_in && cnt_ff[0] == 1'b0) |=> !tick_out)
		else $error("PWM predivider ticked on an even count");

endmodule : pcc_pwm_div
`default_nettype wire

// file: hdl/pcc_top.sv
// Purpose: Loop and PWM clock control fields of the run-mode clock configuration
// Assumes: Clocks are modelled as one-cycle enables on mclk_in
// Notes: Fields outside this block read as zero in the configuration word
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcc_top #(
	parameter int TIMEOUT_CYC = pcc_pkg::LOOP_TIMEOUT_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        arst_n_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output var  logic [31:0] rdata_out,
	input  wire logic        osc_tick_in,
	input  wire logic        loop_tick_in,
	input  wire logic [3:0]  sys_divisor_in,
	input  wire logic        system_divider_select_in,
	output var  logic        sysclk_tick_out,
	output var  logic        pwm_tick_out,
	output var  logic        loop_power_off_out,
	output var  logic        loop_output_drive_n_out,
	output var  logic        loop_clk_out,
	output var  logic        irq_out
);
	import pcc_pkg::*;

	localparam int WD_W = $clog2(TIMEOUT_CYC + 1);

	if (TIMEOUT_CYC < 2) begin : g_chk
		$error("TIMEOUT_CYC must be at least 2");
	end

	logic            pwm_sel_ff;
	logic [2:0]      pwm_clock_predivider_ff;
	logic            loop_power_off_ff;
	logic            loop_output_drive_n_ff;
	logic            bypass_ff;
	logic            loop_check_timer_on_ff;
	logic [0:0]      int_status_ff;
	logic [0:0]      int_enable_ff;
	logic [3:0]      div_cnt_ff;
	logic [WD_W-1:0] wd_cnt_ff;
	logic            wr_cfg;
	logic            wr_ena;
	logic            wr_clr;
	logic            loop_run;
	logic            loop_gated;
	logic            src_tick;
	logic            use_div;
	logic            div_hit;
	logic            sys_tick;
	logic            pwm_div_tick;
	logic            fail_evt;
	logic [31:0]     cfg_word;
	logic [31:0]     nxt_rdata;

	assign wr_cfg = wr_in && (addr_in == ADDR_CLK_CFG);
	assign wr_ena = wr_in && (addr_in == ADDR_INT_ENABLE);
	assign wr_clr = wr_in && (addr_in == ADDR_INT_CLEAR);

	// Configuration fields with their reset values
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwm_sel_ff              <= RST_PWM_SEL;
			pwm_clock_predivider_ff <= RST_PWM_CLOCK_PREDIVIDER;
			loop_power_off_ff       <= RST_LOOP_POWER_OFF;
			loop_output_drive_n_ff  <= RST_OEN;
			bypass_ff               <= RST_BYPASS;
			loop_check_timer_on_ff  <= RST_CHECK;
		end else if (wr_cfg) begin
			pwm_sel_ff              <= wdata_in[BIT_PWM_SEL];
			pwm_clock_predivider_ff <= wdata_in[PWM_CLOCK_PREDIVIDER_MSB:PWM_CLOCK_PREDIVIDER_LSB];
			loop_power_off_ff       <= wdata_in[BIT_LOOP_POWER_OFF];
			loop_output_drive_n_ff  <= wdata_in[BIT_OEN];
			bypass_ff               <= wdata_in[BIT_BYPASS];
			loop_check_timer_on_ff  <= wdata_in[BIT_CHECK];
		end
	end

	// R4: loop run condition
	assign loop_run = !loop_power_off_ff && !loop_output_drive_n_ff;
	// R3: gate loop clock
	assign loop_gated = loop_tick_in && loop_run;

	// R2: drive power-down pin
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			loop_power_off_out      <= RST_LOOP_POWER_OFF;
			loop_output_drive_n_out <= RST_OEN;
		end else begin
			loop_power_off_out      <= loop_power_off_ff;
			loop_output_drive_n_out <= loop_output_drive_n_ff;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			loop_clk_out <= 1'b0;
		end else begin
			loop_clk_out <= loop_gated;
		end
	end

	// R5: bypass source select
	assign src_tick = bypass_ff ? osc_tick_in : loop_gated;
	// R11: divider forced on loop
	assign use_div  = !bypass_ff || system_divider_select_in;
	assign div_hit  = src_tick && (div_cnt_ff >= sys_divisor_in);
	// R6: divided loop clock
	assign sys_tick = use_div ? div_hit : src_tick;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_cnt_ff <= 4'h0;
		end else if (div_hit) begin
			div_cnt_ff <= 4'h0;
		end else if (src_tick) begin
			div_cnt_ff <= div_cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sysclk_tick_out <= 1'b0;
		end else begin
			sysclk_tick_out <= sys_tick;
		end
	end

	pcc_pwm_div #(
		.CNT_W       (6)
	) u_pwm_div (
		.mclk_in     (mclk_in),
		.arst_n_in   (arst_n_in),
		.sys_tick_in (sysclk_tick_out),
		.code_in     (pwm_clock_predivider_ff),
		.tick_out    (pwm_div_tick)
	);

	// R10: PWM clock select
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwm_tick_out <= 1'b0;
		end else begin
			pwm_tick_out <= pwm_sel_ff ? pwm_div_tick : sysclk_tick_out;
		end
	end

	// R8: loop check timer
	assign fail_evt = loop_check_timer_on_ff && loop_run && !loop_tick_in
		&& (wd_cnt_ff == WD_W'(TIMEOUT_CYC - 1));

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wd_cnt_ff <= '0;
		end else if (!loop_check_timer_on_ff || !loop_run || loop_tick_in || fail_evt) begin
			wd_cnt_ff <= '0;
		end else begin
			wd_cnt_ff <= wd_cnt_ff + 1'b1;
		end
	end

	// Sticky status, set wins over clear
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			int_status_ff <= 1'b0;
		end else if (fail_evt) begin
			int_status_ff[INT_LOOP_FAIL] <= 1'b1;
		end else if (wr_clr && wdata_in[INT_LOOP_FAIL]) begin
			int_status_ff[INT_LOOP_FAIL] <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			int_enable_ff <= 1'b0;
		end else if (wr_ena) begin
			int_enable_ff <= wdata_in[INT_LOOP_FAIL];
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(int_status_ff & int_enable_ff);
		end
	end

	// R1: reserved read zero
	always_comb begin
		cfg_word                        = 32'h0000_0000;
		cfg_word[BIT_PWM_SEL]           = pwm_sel_ff;
		cfg_word[PWM_CLOCK_PREDIVIDER_MSB:PWM_CLOCK_PREDIVIDER_LSB] = pwm_clock_predivider_ff;
		cfg_word[BIT_LOOP_POWER_OFF]             = loop_power_off_ff;
		cfg_word[BIT_OEN]               = loop_output_drive_n_ff;
		cfg_word[BIT_BYPASS]            = bypass_ff;
		cfg_word[BIT_CHECK]             = loop_check_timer_on_ff;
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (addr_in == ADDR_CLK_CFG) begin
			nxt_rdata = cfg_word;
		end else if (addr_in == ADDR_INT_STATUS) begin
			nxt_rdata = {31'h0000_0000, int_status_ff};
		end else if (addr_in == ADDR_INT_ENABLE) begin
			nxt_rdata = {31'h0000_0000, int_enable_ff};
		end
	end

	// Read data stand one cycle only
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_in) begin
			rdata_out <= nxt_rdata;
		end else begin
			rdata_out <= 32'h0000_0000;
		end
	end

	AST_RSVD_ZERO: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R1
		(rd_in && addr_in == ADDR_CLK_CFG) |=> rdata_out[RSVD_MSB:RSVD_LSB] == 3'h0)
		else $error("Reserved configuration bits read nonzero");

	AST_LOOP_POWER_OFF_PIN: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R2
		wr_cfg |=> ##1 loop_power_off_out == $past(wdata_in[BIT_LOOP_POWER_OFF], 2))
		else $error("Power-down pin does not follow written bit");

	AST_LOOP_QUIET: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R3
		loop_output_drive_n_out |-> !loop_clk_out)
		else $error("Loop clock toggles with output driver off");

	AST_LOOP_RUN: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R4
		(loop_tick_in && !loop_power_off_ff && !loop_output_drive_n_ff) |=> loop_clk_out)
		else $error("Loop clock not passed while loop runs");

	AST_LOOP_LOOP_POWER_OFF: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R4
		loop_power_off_out |-> !loop_clk_out)
		else $error("Loop clock toggles while powered down");

	AST_BYPASS_OSC: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R5
		(bypass_ff && !system_divider_select_in) |=> sysclk_tick_out == $past(osc_tick_in))
		else $error("Bypass does not pass oscillator clock");

	AST_LOOP_SRC: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R6
		(!bypass_ff && !loop_tick_in) |=> !sysclk_tick_out)
		else $error("System tick without loop tick in loop mode");

	AST_DIV_FORCED: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R11
		(!bypass_ff && !system_divider_select_in && src_tick
		&& div_cnt_ff < sys_divisor_in) |=> !sysclk_tick_out)
		else $error("Divider not applied to loop source");

	AST_CHECK_OFF: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R8
		!loop_check_timer_on_ff |-> (!fail_evt && wd_cnt_ff == '0) or $past(wr_cfg))
		else $error("Check timer active while disabled");

	AST_CHECK_IRQ: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R8
		(fail_evt && int_enable_ff[INT_LOOP_FAIL]) |=> ##1 irq_out)
		else $error("Loop failure did not raise interrupt");

	AST_PWM_DIRECT: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R10
		!pwm_sel_ff |=> pwm_tick_out == $past(sysclk_tick_out))
		else $error("PWM clock not system clock when unselected");

	AST_PWM_SEL: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R10
		pwm_sel_ff |=> pwm_tick_out == $past(pwm_div_tick))
		else $error("PWM clock not predivided when selected");

	AST_OEN_PIN: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R3
		wr_cfg |=> ##1 loop_output_drive_n_out == $past(wdata_in[BIT_OEN], 2))
		else $error("Output driver pin does not follow written bit");

	AST_CHECK_BOUND: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R8
		wd_cnt_ff <= WD_W'(TIMEOUT_CYC - 1))
		else $error("Check timer ran past its timeout");

	AST_STATUS_STICKY: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R8
		(int_status_ff[INT_LOOP_FAIL] && !(wr_clr && wdata_in[INT_LOOP_FAIL]))
		|=> int_status_ff[INT_LOOP_FAIL])
		else $error("Loop failure status lost without a clear");

	AST_IRQ_LEVEL: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // R8
		irq_out == $past(int_status_ff[INT_LOOP_FAIL] && int_enable_ff[INT_LOOP_FAIL]))
		else $error("Interrupt does not follow enabled status");

	COV_LOOP_FAIL: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
		fail_evt ##2 irq_out);

	COV_LOOP_SYS: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
		!bypass_ff && sysclk_tick_out);

	COV_PWM_DIV: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
		pwm_sel_ff && pwm_tick_out);

	COV_SET_CLEAR: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
		fail_evt && wr_clr);

	COV_LOOP_DIV: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
		!bypass_ff && sys_divisor_in != 4'h0 && sysclk_tick_out);

endmodule : pcc_top
`default_nettype wire

// file: testbench/pcc_testbench.sv
// Purpose: Self-checking bench for the loop and PWM clock control block
// Assumes: Loop check timeout shortened to 4 cycles
// Notes: Register readback and tick counts compared with a bench model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pcc_pkg::*;
	localparam int TMO = 4;
	logic        mclk_in                  = 1'b0;
	logic        arst_n_in                = 1'b0;
	logic [7:0]  addr_in                  = 8'h00;
	logic [31:0] wdata_in                 = 32'h0;
	logic        wr_in                    = 1'b0;
	logic        rd_in                    = 1'b0;
	logic        osc_tick_in              = 1'b0;
	logic        loop_tick_in             = 1'b0;
	logic [3:0]  sys_divisor_in           = 4'h0;
	logic        system_divider_select_in = 1'b0;
	logic [31:0] rdata_out;
	logic [31:0] rd_val;
	logic [31:0] cfg_m;
	logic        sysclk_tick_out;
	logic        pwm_tick_out;
	logic        loop_power_off_out;
	logic        loop_output_drive_n_out;
	logic        loop_clk_out;
	logic        irq_out;
	int          fail_count      = 0;
	int          samples_checked = 0;
	int          seed            = 73;
	int          n_sys           = 0;
	int          n_pwm           = 0;
	int          n_loop          = 0;
	int          b_sys;
	int          b_pwm;
	int          b_loop;
	int          k;

	pcc_top #(.TIMEOUT_CYC(TMO)) u_dut (
		.mclk_in                  (mclk_in),
		.arst_n_in                (arst_n_in),
		.addr_in                  (addr_in),
		.wdata_in                 (wdata_in),
		.wr_in                    (wr_in),
		.rd_in                    (rd_in),
		.rdata_out                (rdata_out),
		.osc_tick_in              (osc_tick_in),
		.loop_tick_in             (loop_tick_in),
		.sys_divisor_in           (sys_divisor_in),
		.system_divider_select_in (system_divider_select_in),
		.sysclk_tick_out          (sysclk_tick_out),
		.pwm_tick_out             (pwm_tick_out),
		.loop_power_off_out       (loop_power_off_out),
		.loop_output_drive_n_out  (loop_output_drive_n_out),
		.loop_clk_out             (loop_clk_out),
		.irq_out                  (irq_out)
	);

	always #2.5 mclk_in = ~mclk_in;

	// Tick counters
	always @(posedge mclk_in) begin
		if (sysclk_tick_out === 1'b1) n_sys <= n_sys + 1;
		if (pwm_tick_out === 1'b1) n_pwm <= n_pwm + 1;
		if (loop_clk_out === 1'b1) n_loop <= n_loop + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic end_test(input string s);
		$display("test %s finished", s);
	endtask : end_test

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		@(posedge mclk_in);
		rd_val = rdata_out;
	endtask : reg_rd

	task automatic set_cfg(input logic [31:0] d, input logic dsel, input logic [3:0] dv);
		system_divider_select_in <= dsel;
		sys_divisor_in           <= dv;
		reg_wr(ADDR_CLK_CFG, d);
		cfg_m = d & 32'h001e3c00;
	endtask : set_cfg

	task automatic pulse(input logic osc, input logic lp, input int n);
		b_sys  = n_sys;
		b_pwm  = n_pwm;
		b_loop = n_loop;
		@(posedge mclk_in);
		osc_tick_in  <= osc;
		loop_tick_in <= lp;
		repeat (n) @(posedge mclk_in);
		osc_tick_in  <= 1'b0;
		loop_tick_in <= 1'b0;
		repeat (5) @(posedge mclk_in);
	endtask : pulse

	initial begin
		repeat (3) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		cfg_m = 32'h000e3800;
		#1;
		check({31'h0, loop_power_off_out}, 32'h1, "power off at reset");
		check({31'h0, loop_output_drive_n_out}, 32'h1, "drive off at reset");
		reg_rd(ADDR_CLK_CFG);
		check(rd_val, cfg_m, "config reset");
		reg_rd(8'h7c);
		check(rd_val, 32'h0, "unmapped read");
		end_test("reset");
		for (k = 0; k < 8; k++) begin
			set_cfg($random(seed), 1'b0, 4'h0);
			reg_rd(ADDR_CLK_CFG);
			check(rd_val, cfg_m, "config readback");
			check({31'h0, loop_power_off_out}, {31'h0, cfg_m[13]}, "power pin");
			check({31'h0, loop_output_drive_n_out}, {31'h0, cfg_m[12]}, "drive pin");
		end
		end_test("fields");
		for (k = 0; k < 4; k++) begin
			set_cfg({18'h0, k[1:0], 12'h800}, 1'b0, 4'h0);
			pulse(1'b0, 1'b1, 8);
			check(32'(n_loop - b_loop), (k == 0) ? 32'd8 : 32'd0, "loop clock");
		end
		end_test("gating");
		set_cfg(32'h00000800, 1'b0, 4'h2);
		pulse(1'b1, 1'b0, 12);
		check(32'(n_sys - b_sys), 32'd12, "osc direct");
		check(32'(n_pwm - b_pwm), 32'd12, "pwm undivided");
		pulse(1'b0, 1'b1, 12);
		check(32'(n_sys - b_sys), 32'd0, "loop ignored");
		set_cfg(32'h00000800, 1'b1, 4'h2);
		pulse(1'b1, 1'b0, 12);
		check(32'(n_sys - b_sys), 32'd4, "osc divided");
		set_cfg(32'h00000000, 1'b0, 4'h2);
		pulse(1'b0, 1'b1, 12);
		check(32'(n_sys - b_sys), 32'd4, "loop divided");
		pulse(1'b1, 1'b0, 12);
		check(32'(n_sys - b_sys), 32'd0, "osc ignored");
		end_test("source");
		for (k = 0; k < 8; k++) begin
			set_cfg({11'h0, 1'b1, k[2:0], 5'h0, 12'h800}, 1'b0, 4'h0);
			pulse(1'b1, 1'b0, 128);
			check(32'(n_pwm - b_pwm), 32'(128 >> ((k < 5) ? k + 1 : 6)), "pwm ticks");
		end
		end_test("predivider");
		set_cfg(32'h00000000, 1'b0, 4'h0);
		reg_wr(ADDR_INT_CLEAR, 32'h1);
		reg_wr(ADDR_INT_STATUS, 32'h1);
		repeat (20) @(posedge mclk_in);
		reg_rd(ADDR_INT_STATUS);
		check(rd_val, 32'h0, "timer idle");
		reg_wr(ADDR_INT_ENABLE, 32'h1);
		set_cfg(32'h00000400, 1'b0, 4'h0);
		for (k = 0; k < TMO + 6 && irq_out !== 1'b1; k++) @(posedge mclk_in);
		if (irq_out !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: no interrupt", $time);
			test_done();
		end
		reg_rd(ADDR_INT_STATUS);
		check(rd_val, 32'h1, "status set");
		reg_wr(ADDR_INT_ENABLE, 32'h0);
		repeat (2) @(posedge mclk_in);
		#1 check({31'h0, irq_out}, 32'h0, "masked");
		reg_wr(ADDR_INT_ENABLE, 32'h1);
		repeat (2) @(posedge mclk_in);
		#1 check({31'h0, irq_out}, 32'h1, "unmasked");
		set_cfg(32'h00000000, 1'b0, 4'h0);
		reg_wr(ADDR_INT_CLEAR, 32'h1);
		reg_rd(ADDR_INT_CLEAR);
		check(rd_val, 32'h0, "clear reads zero");
		reg_rd(ADDR_INT_STATUS);
		check(rd_val, 32'h0, "status cleared");
		check({31'h0, irq_out}, 32'h0, "irq low");
		end_test("timer");
		test_done();
	end
endmodule : testbench
`default_nettype wire
